// file: logic/pps_priority_pause.sv
/*
 Per-priority pause signalling: receive pause requests to eight FIFOs with quanta expiry
 gated by acknowledge, and transmit pause frame requests with automatic refresh.
 Assumes one clock, synchronous active-low reset, and a transmitter that signals
 the points where a pause frame may be inserted and when it has been sent.
*/
`timescale 1ns/10ps
`include "pps_consts.svh"

module pps_priority_pause
    import pps_pkg::*;
#(
    parameter bit          PFC_ENABLE       = `PPS_PFC_EN_DEFAULT,
    parameter int unsigned NUM_PRIO         = `PPS_NUM_PRIO,
    parameter int unsigned CYC_PER_QUANTUM  = `PPS_CYC_PER_QUANTUM
) (
    input  wire logic                  clk,
    input  wire logic                  nrst,
    input  wire pps_rx_frame_t         rx_pause_frame,
    output logic [NUM_PRIO-1:0]        rx_prio_pause_req,
    input  wire logic [NUM_PRIO-1:0]   rx_prio_pause_ack,
    input  wire logic [NUM_PRIO-1:0]   tx_prio_pause_req,
    input  wire pps_tx_cfg_t           tx_cfg,
    input  wire logic                  tx_slot_free,
    input  wire logic                  tx_frame_done,
    output pps_tx_frame_t              tx_pause_frame
);

    // ==========================================================
    // Quantum tick
    // ==========================================================
    // One pause quantum is 512 bit times, a fixed number of datapath cycles.
    localparam int unsigned TW = (CYC_PER_QUANTUM > 1) ? $clog2(CYC_PER_QUANTUM) : 1;

    logic [TW-1:0] tick_cnt_r;
    logic [TW-1:0] tick_cnt_nxt;
    wire           tick = (tick_cnt_r == TW'(CYC_PER_QUANTUM - 1));

    assign tick_cnt_nxt = tick ? '0 : tick_cnt_r + 1'b1;

    // The tick runs free, so every priority expires on one shared quantum grid.
    // Receive expiry and the transmit refresh counters both step on it.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick_cnt_nxt;
        end
    end

    // ==========================================================
    // Receive side: per-priority captured quanta
    // ==========================================================
    logic [NUM_PRIO-1:0] rx_req_int;

    genvar p;
    generate
        for (p = 0; p < NUM_PRIO; p = p + 1) begin : g_rx
            pps_quanta_t rx_q_r;
            pps_quanta_t rx_q_nxt;
            wire         capture = rx_pause_frame.valid && rx_pause_frame.enable_vec[p];
            wire         expire  = rx_prio_pause_ack[p] && tick && (rx_q_r != '0);

            // A new frame reloads the count and wins over expiry in the same cycle.
            // Without acknowledge the count holds, however long the FIFO takes to answer.
            assign rx_q_nxt = capture ? rx_pause_frame.quanta[p] :
                              expire  ? rx_q_r - 1'b1 : rx_q_r;
            assign rx_req_int[p] = (rx_q_r != '0);

            always_ff @(posedge clk) begin
                if (!nrst) begin
                    rx_q_r <= `PPS_QUANTA_RST;
                end else begin
                    rx_q_r <= rx_q_nxt;
                end
            end
        end
    endgenerate

    // ==========================================================
    // Transmit side: refresh counters per priority
    // ==========================================================
    // Each counter models the quanta still running at the far end since the last frame.
    logic [NUM_PRIO-1:0] refresh_due;
    logic [NUM_PRIO-1:0] req_prev_r;
    logic [NUM_PRIO-1:0] pend_r;
    logic [NUM_PRIO-1:0] pend_nxt;
    logic [NUM_PRIO-1:0] sent_vec_r;
    wire                 frame_sent;
    wire                 launch;
    wire [NUM_PRIO-1:0][`PPS_QUANTA_W-1:0] quanta_sel;

    generate
        for (p = 0; p < NUM_PRIO; p = p + 1) begin : g_tx
            pps_quanta_t tx_q_r;
            pps_quanta_t tx_q_nxt;
            wire         rise       = tx_prio_pause_req[p] && !req_prev_r[p];
            wire         sent_here  = frame_sent && sent_vec_r[p];
            wire         count_down = tick && (tx_q_r != '0);

            // The refresh level is read live so a config change acts at once.
            assign refresh_due[p] = tx_prio_pause_req[p] && (tx_q_r == tx_cfg.refresh[p])
                                    && !pend_r[p] && !sent_vec_r[p];

            // Pending clears when the frame is launched, not when it ends, so a request
            // that rises while a frame is on the wire is kept for the next frame.
            // A new request wins over the clear in the same cycle.
            assign pend_nxt[p]    = (rise || refresh_due[p]) ? 1'b1 :
                                    launch ? 1'b0 : pend_r[p];

            // A sent frame restarts the count that mirrors the far end's pause timer.
            assign tx_q_nxt       = sent_here  ? tx_cfg.quanta[p] :
                                    count_down ? tx_q_r - 1'b1 : tx_q_r;

            // Frame quanta: the configured value while requested, zero (XON) once released.
            assign quanta_sel[p]  = tx_prio_pause_req[p] ? tx_cfg.quanta[p] : '0;

            always_ff @(posedge clk) begin
                if (!nrst) begin
                    tx_q_r <= `PPS_QUANTA_RST;
                end else begin
                    tx_q_r <= tx_q_nxt;
                end
            end
        end
    endgenerate

    // The previous request level gives the rising edge that starts a new pause.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            req_prev_r <= '0;
            pend_r     <= '0;
        end else begin
            req_prev_r <= tx_prio_pause_req;
            pend_r     <= pend_nxt;
        end
    end

    // ==========================================================
    // Transmit frame request sequencer
    // ==========================================================
    pps_tx_state_t state_r;
    pps_tx_state_t state_nxt;
    pps_tx_frame_t frame_r;
    pps_tx_frame_t frame_nxt;
    logic [NUM_PRIO-1:0] sent_vec_nxt;

    wire any_pend  = |pend_r;
    assign launch     = (state_r == PPS_TX_WAIT) && tx_slot_free;
    assign frame_sent = (state_r == PPS_TX_SEND) && tx_frame_done;

    // The sequencer waits for a free slot, holds the request until the frame is
    // reported sent, then idles one cycle before it looks at pending work again.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PPS_TX_IDLE: begin
                if (any_pend) begin
                    state_nxt = PPS_TX_WAIT;
                end
            end
            PPS_TX_WAIT: begin
                if (tx_slot_free) begin
                    state_nxt = PPS_TX_SEND;
                end
            end
            PPS_TX_SEND: begin
                if (tx_frame_done) begin
                    state_nxt = PPS_TX_IDLE;
                end
            end
            default:     state_nxt = PPS_TX_IDLE;
        endcase
    end

    // A frame carries every pending priority; released ones carry zero quanta (XON).
    always_comb begin
        frame_nxt    = frame_r;
        sent_vec_nxt = sent_vec_r;
        if (launch) begin
            frame_nxt.valid      = 1'b1;
            frame_nxt.enable_vec = pend_r;
            for (int i = 0; i < NUM_PRIO; i++) begin
                frame_nxt.quanta[i] = quanta_sel[i];
            end
            sent_vec_nxt = pend_r;
        end else if (frame_sent) begin
            frame_nxt.valid = 1'b0;
            sent_vec_nxt    = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_r    <= PPS_TX_IDLE;
            frame_r    <= '0;
            sent_vec_r <= '0;
        end else begin
            state_r    <= state_nxt;
            frame_r    <= frame_nxt;
            sent_vec_r <= sent_vec_nxt;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    // Builds without priority flow control hold every output inactive.
    // The ports stay in place, so the surrounding wiring is the same in both builds.
    assign rx_prio_pause_req = PFC_ENABLE ? rx_req_int : '0;
    assign tx_pause_frame    = PFC_ENABLE ? frame_r : '0;

endmodule : pps_priority_pause

// file: logic/pps_consts.svh
/*
 Constants of the per-priority pause signalling block: counts, widths, reset values.
 Assumes it is included by its bare name from the package and the design file.
*/
`ifndef PPS_CONSTS_SVH
`define PPS_CONSTS_SVH

`define PPS_NUM_PRIO        8
`define PPS_QUANTA_W        16
`define PPS_QUANTUM_BITS    512
`define PPS_DATA_W          64
`define PPS_CYC_PER_QUANTUM (`PPS_QUANTUM_BITS / `PPS_DATA_W)
`define PPS_QUANTA_RST      16'h0000
`define PPS_PFC_EN_DEFAULT  1'b1

`endif

// file: logic/pps_pkg.sv
/*
 Types of the per-priority pause signalling block.
 Assumes pps_consts.svh is on the include path.
*/
`include "pps_consts.svh"

package pps_pkg;

    typedef logic [`PPS_QUANTA_W-1:0] pps_quanta_t;

    // Received priority pause frame as decoded by the receive path.
    typedef struct packed {
        logic                      valid;
        logic [`PPS_NUM_PRIO-1:0]  enable_vec;
        pps_quanta_t [`PPS_NUM_PRIO-1:0] quanta;
    } pps_rx_frame_t;

    // Transmit configuration: quanta to send and refresh levels per priority.
    typedef struct packed {
        pps_quanta_t [`PPS_NUM_PRIO-1:0] refresh;
        pps_quanta_t [`PPS_NUM_PRIO-1:0] quanta;
    } pps_tx_cfg_t;

    // Request to the transmitter to insert one priority pause frame.
    typedef struct packed {
        logic                      valid;
        logic [`PPS_NUM_PRIO-1:0]  enable_vec;
        pps_quanta_t [`PPS_NUM_PRIO-1:0] quanta;
    } pps_tx_frame_t;

    typedef enum logic [1:0] {
        PPS_TX_IDLE,
        PPS_TX_WAIT,
        PPS_TX_SEND
    } pps_tx_state_t;

endpackage : pps_pkg

// file: test/pps_pause_monitor.sv
/* Port checker for the pause block.
   Assumes it is bound onto pps_priority_pause built with eight priorities. */
`timescale 1ns/10ps
module pps_pause_monitor
    import pps_pkg::*;
(
    input wire logic          clk,
    input wire logic          nrst,
    input wire pps_rx_frame_t rx_pause_frame,
    input wire logic [7:0]    rx_prio_pause_req,
    input wire logic [7:0]    rx_prio_pause_ack,
    input wire logic [7:0]    tx_prio_pause_req,
    input wire pps_tx_cfg_t   tx_cfg,
    input wire logic          tx_slot_free,
    input wire logic          tx_frame_done,
    input wire pps_tx_frame_t tx_pause_frame
);
    // ========
    // Checks
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic [7:0] ld_en;
    logic [7:0] ld_nz;
    assign ld_en = rx_pause_frame.valid ? rx_pause_frame.enable_vec : 8'h00;
    always_comb
        for (int p = 0; p < 8; p++) ld_nz[p] = ld_en[p] && rx_pause_frame.quanta[p] != 16'h0000;
    chk_load_match:
        assert property (|ld_en |=> ((rx_prio_pause_req ^ $past(ld_nz)) & $past(ld_en)) == 8'h00)
        else $error("load mismatch");
    chk_hold_noack:
        assert property (!rx_pause_frame.valid |=>
            ($past(rx_prio_pause_req) & ~$past(rx_prio_pause_ack) & ~rx_prio_pause_req) == 8'h00)
        else $error("expiry without ack");
    chk_launch_slot:
        assert property ($rose(tx_pause_frame.valid) |-> $past(tx_slot_free))
        else $error("launch without slot");
    chk_frame_prio:
        assert property ($rose(tx_pause_frame.valid) |-> tx_pause_frame.enable_vec != 8'h00)
        else $error("frame names no priority");
    chk_frame_hold:
        assert property (tx_pause_frame.valid && !tx_frame_done |=> $stable(tx_pause_frame))
        else $error("frame changed early");
    chk_frame_clear:
        assert property (tx_pause_frame.valid && tx_frame_done |=> !tx_pause_frame.valid)
        else $error("frame not cleared");
    chk_quanta_live:
        assert property ($rose(tx_pause_frame.valid) && tx_pause_frame.enable_vec[2] |->
            tx_pause_frame.quanta[2] ==
            ($past(tx_prio_pause_req[2]) ? $past(tx_cfg.quanta[2]) : 16'h0000))
        else $error("stale quanta");
    cover property (|ld_nz);
    cover property (rx_prio_pause_req[7] && !rx_prio_pause_ack[7]);
    cover property ($rose(tx_pause_frame.valid));
endmodule : pps_pause_monitor
bind pps_priority_pause pps_pause_monitor mon (.clk, .nrst, .rx_pause_frame, .rx_prio_pause_req,
    .rx_prio_pause_ack, .tx_prio_pause_req, .tx_cfg, .tx_slot_free, .tx_frame_done,
    .tx_pause_frame);

// file: test/pps_fifo_model.sv
/* Receive FIFO stand-in that acknowledges pause requests one cycle late.
   Assumes the bench picks the unused and the stalled priorities. */
`timescale 1ns/10ps
module pps_fifo_model (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic [7:0] rx_prio_pause_req,
    input  wire logic [7:0] unused_m,
    input  wire logic [7:0] stall_m,
    output logic [7:0]      rx_prio_pause_ack
);
    logic [7:0] ack_r;
    assign rx_prio_pause_ack = ack_r | unused_m;
    always_ff @(posedge clk) ack_r <= nrst ? (rx_prio_pause_req & ~stall_m) : 8'h00;
endmodule : pps_fifo_model

// file: test/pps_priority_pause_bench.sv
/* Bench for the pause block: receive expiry, transmit launch and refresh.
   Assumes the FIFO model and the bound checker are compiled first. */
`timescale 1ns/10ps
module pps_priority_pause_bench
    import pps_pkg::*;
;
    logic          clk = 1'b0, nrst = 1'b0, tx_slot_free = 1'b0, tx_frame_done = 1'b0;
    logic [7:0]    tx_prio_pause_req = 8'h00, unused_m = 8'h7e, stall_m = 8'h80;
    logic [7:0]    rx_prio_pause_req, rx_prio_pause_ack;
    pps_rx_frame_t rx_pause_frame = '0;
    pps_tx_cfg_t   tx_cfg = '0;
    pps_tx_frame_t tx_pause_frame;
    int            bad_count = 0, n_tests = 0, cyc = 0;
    always #2 clk = ~clk;
    pps_priority_pause uut (.clk, .nrst, .rx_pause_frame, .rx_prio_pause_req, .rx_prio_pause_ack,
        .tx_prio_pause_req, .tx_cfg, .tx_slot_free, .tx_frame_done, .tx_pause_frame);
    pps_fifo_model fifo (.clk, .nrst, .rx_prio_pause_req, .unused_m, .stall_m, .rx_prio_pause_ack);
    // ========
    // Helpers
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task send_rx(input int p, input logic [15:0] q);
        @(posedge clk);
        rx_pause_frame.valid <= 1'b1;
        rx_pause_frame.enable_vec <= 8'h01 << p;
        rx_pause_frame.quanta[p] <= q;
        @(posedge clk);
        rx_pause_frame.valid <= 1'b0;
    endtask : send_rx
    task wait_frame(input int n);
        for (int i = 0; i < n && tx_pause_frame.valid !== 1'b1; i++) @(posedge clk);
        chk(tx_pause_frame.valid, 16'h0001);
    endtask : wait_frame
    task finish_frame;
        tx_frame_done <= 1'b1;
        @(posedge clk);
        tx_frame_done <= 1'b0;
        repeat (2) @(posedge clk);
        chk(tx_pause_frame.valid, 16'h0000);
    endtask : finish_frame
    task print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : print_verdict
    // ========
    // Scenarios
    task test_rx;
        send_rx(0, 16'h0002);
        send_rx(7, 16'h0003);
        @(posedge clk);
        chk(rx_prio_pause_req, 16'h0081);
        repeat (40) @(posedge clk);
        chk(rx_prio_pause_req, 16'h0080);
        stall_m <= 8'h00;
        repeat (40) @(posedge clk);
        chk(rx_prio_pause_req, 16'h0000);
        send_rx(1, 16'h0005);
        @(posedge clk);
        chk(rx_prio_pause_req, 16'h0002);
        repeat (48) @(posedge clk);
        chk(rx_prio_pause_req, 16'h0000);
        send_rx(1, 16'h0005);
        send_rx(1, 16'h0000);
        @(posedge clk);
        chk(rx_prio_pause_req, 16'h0000);
        $display("test rx finished");
    endtask : test_rx
    task test_tx;
        tx_cfg.quanta[2] <= 16'h0010;
        tx_cfg.refresh[2] <= 16'h0004;
        tx_prio_pause_req <= 8'h04;
        repeat (6) @(posedge clk);
        chk(tx_pause_frame.valid, 16'h0000);
        tx_slot_free <= 1'b1;
        wait_frame(10);
        chk(tx_pause_frame.enable_vec, 16'h0004);
        chk(tx_pause_frame.quanta[2], 16'h0010);
        finish_frame();
        tx_cfg.quanta[2] <= 16'h0020;
        repeat (80) @(posedge clk);
        chk(tx_pause_frame.valid, 16'h0000);
        wait_frame(40);
        chk(tx_pause_frame.quanta[2], 16'h0020);
        tx_prio_pause_req <= 8'h00;
        finish_frame();
        $display("test tx finished");
    endtask : test_tx
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            bad_count++;
            print_verdict();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        test_rx();
        test_tx();
        print_verdict();
    end
endmodule : pps_priority_pause_bench
